/* hw/afr_cfg.svh */
// Register offsets, field positions, reset values for the AFE register bank
// Assumes an 8-bit register bus with byte offsets 0..14
`ifndef AFR_CFG_SVH
`define AFR_CFG_SVH

`define AFR_ADDR_W          4
`define AFR_OFS_SUPPLY      4'h0
`define AFR_OFS_GAIN        4'h1
`define AFR_OFS_INCONN      4'h2
`define AFR_OFS_CHSEL       4'h3
`define AFR_OFS_RES_LO      4'h4
`define AFR_OFS_RES_MID     4'h5
`define AFR_OFS_RES_HI      4'h6
`define AFR_OFS_CCTL0       4'h7
`define AFR_OFS_CCTL1       4'h8
`define AFR_OFS_CLKSEL      4'h9
`define AFR_OFS_DAC_LO      4'hA
`define AFR_OFS_DAC_HI      4'hB
`define AFR_OFS_DAC_CTL     4'hC
`define AFR_OFS_OPAMP       4'hD
`define AFR_OFS_VCMSW       4'hE

// Implemented-bit masks, everything else reads zero
`define AFR_MSK_SUPPLY      8'h87
`define AFR_MSK_GAIN        8'h7F
`define AFR_MSK_INCONN      8'h7E
`define AFR_MSK_CHSEL       8'hFF
`define AFR_MSK_CCTL0       8'hFD
`define AFR_MSK_CCTL1       8'hE6
`define AFR_MSK_CLKSEL      8'h1F
`define AFR_MSK_DAC_LO      8'h0F
`define AFR_MSK_DAC_CTL     8'hC3
`define AFR_MSK_OPAMP       8'h8F
`define AFR_MSK_VCMSW       8'h0F

// Reset values
`define AFR_RST_ZERO        8'h00
`define AFR_RST_CCTL0       8'h20
`define AFR_RST_VCMSW       8'h0A

// Field positions
`define AFR_BIT_SHORT       6
`define AFR_BIT_DAC_EN      7
`define AFR_BIT_DAC_REF     6
`define AFR_BIT_DAC_PIN     1
`define AFR_BIT_DAC_AMP     0

// Highest legal channel codes and the reserved two-bit gain code
`define AFR_NEG_MAX         4'h8
`define AFR_POS_MAX         4'h7
`define AFR_GAIN2_RSVD      2'h3

`endif

/* hw/afr_pkg.sv */
// Types shared by the AFE register bank
// Assumes afr_cfg.svh supplies the numeric constants
package afr_pkg;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } afr_bus_s;

   typedef struct packed {
      logic [1:0] ref_gain_sel;
      logic [1:0] conv_gain_sel;
      logic [2:0] amp_gain_sel;
      logic       input_short;
      logic [1:0] input_cross_sel;
      logic [2:0] offset_sel;
      logic [3:0] neg_input_sel;
      logic [3:0] pos_input_sel;
   } afr_front_s;

   typedef struct packed {
      logic        dac_enable;
      logic        dac_ref_sel;
      logic        dac_pin_route;
      logic        dac_amp_route;
      logic [11:0] code;
   } afr_dac_s;

   typedef enum logic [1:0] {
      AFR_OFS_ZERO = 2'b00,
      AFR_OFS_ADD  = 2'b01,
      AFR_OFS_SUB  = 2'b11
   } afr_ofs_e;

endpackage

/* hw/afr_regfile.sv */
// Small byte-wide register array with registered read data
// Assumes synchronous reset and one write port, one read port
`include "afr_cfg.svh"
module afr_regfile
   import afr_pkg::*;
#(
   parameter int AW = 4,
   parameter int N  = 15
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          srst,
   // Write port
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [7:0]    wmask,
   // Read port
   input  wire logic          re,
   input  wire logic [AW-1:0] raddr,
   input  wire logic          xsel,
   input  wire logic [7:0]    xdata,
   output logic      [7:0]    rdata
);

   logic [7:0] mem_r [N];

   // Storage with per-entry reset value
   always_ff @(posedge clk) begin
      for (int i = 0; i < N; i++) begin
         if (srst) begin
            mem_r[i] <= (i == int'(`AFR_OFS_CCTL0)) ? `AFR_RST_CCTL0 :
                        (i == int'(`AFR_OFS_VCMSW)) ? `AFR_RST_VCMSW :
                        `AFR_RST_ZERO;
         end else if (we && waddr == AW'(i)) begin
            mem_r[i] <= wdata & wmask;
         end
      end
   end

   // Registered read: quiet when idle, outside byte when selected
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= 8'h00;
      end else if (!re) begin
         rdata <= 8'h00;
      end else if (xsel) begin
         rdata <= xdata;
      end else begin
         rdata <= (int'(raddr) < N) ? mem_r[raddr] : 8'h00;
      end
   end

endmodule // afr_regfile

/* hw/afr_regs.sv */
// AFE register bank: gain, channel, offset and D/A configuration
// Assumes a one-cycle-read register port on clk and a sync reset
//
// Functional notes
// - Reference gain codes 00,01,10 give 1, 1/2, 1/4; 11 reserved.
// - Converter gain bits 4:3 give 1, 2, 4; code 11 reserved.
// - Amplifier gain bits 2:0 give two to the power of the code.
// - Input connection bit 6 shorts the two selected input ends.
// - Offset 000/100 zero; 001-011 add, 101-111 subtract quarters.
// - Negative select codes 0000-1000 valid; 1001-1111 reserved.
// - Positive select codes 0000-0111 valid; 1000-1111 reserved.
// - D/A code is 12 bits: high byte 11:4, low nibble 3:0.
// - Low code write goes to shadow; high write copies it active.
// - D/A control bit 7 enables the converter, resets to zero.
// - D/A control bit 6 picks regulated or input supply reference.
// - D/A control bit 1 routes D/A output to its pin.
// - Bit 0 routes D/A to amp input if pin selected and enabled.
// - Unimplemented bits read zero; control bits reset to zero. Here CCTL0 resets to 20h and VCMSW to 0Ah.
// - 24-bit result in three read-only bytes; writes ignored.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`include "afr_cfg.svh"
module afr_regs
   import afr_pkg::*;
#(
   parameter int AW = `AFR_ADDR_W
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          srst,
   // Register port
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   input  wire logic          wr,
   input  wire logic          rd,
   output logic      [7:0]    rdata,
   // Conversion result from the converter
   input  wire logic [23:0]   conv_result,
   // Decoded analog controls
   output afr_front_s         front,
   output logic      [7:0]    ref_gain_den,
   output logic      [2:0]    conv_gain_log2,
   output logic      [7:0]    amp_gain,
   output logic      [1:0]    offset_quarters,
   output logic               offset_neg,
   output logic               gain_reserved,
   output logic               chan_reserved,
   // D/A controls
   output afr_dac_s           dac,
   output logic               dac_amp_route_eff,
   input  wire logic          amp_pin_func_sel
);

   // Bank-held copies needed by the logic itself
   logic [7:0]  gain_r;
   logic [7:0]  inconn_r;
   logic [7:0]  chsel_r;
   logic [7:0]  dacctl_r;
   logic [3:0]  dac_shadow_r;
   logic [3:0]  dac_lo_r;
   logic [7:0]  dac_hi_r;
   logic [23:0] result_r;

   // Bus decode
   wire afr_bus_s bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   wire wr_gain   = bus.wr && bus.addr == `AFR_OFS_GAIN;
   wire wr_inconn = bus.wr && bus.addr == `AFR_OFS_INCONN;
   wire wr_chsel  = bus.wr && bus.addr == `AFR_OFS_CHSEL;
   wire wr_daclo  = bus.wr && bus.addr == `AFR_OFS_DAC_LO;
   wire wr_dachi  = bus.wr && bus.addr == `AFR_OFS_DAC_HI;
   wire wr_dacctl = bus.wr && bus.addr == `AFR_OFS_DAC_CTL;

   // Write mask per address; result bytes and unmapped are read-only
   function automatic logic [7:0] wmask_of(input logic [AW-1:0] a);
      case (a)
         `AFR_OFS_SUPPLY:  wmask_of = `AFR_MSK_SUPPLY;
         `AFR_OFS_GAIN:    wmask_of = `AFR_MSK_GAIN;
         `AFR_OFS_INCONN:  wmask_of = `AFR_MSK_INCONN;
         `AFR_OFS_CHSEL:   wmask_of = `AFR_MSK_CHSEL;
         `AFR_OFS_CCTL0:   wmask_of = `AFR_MSK_CCTL0;
         `AFR_OFS_CCTL1:   wmask_of = `AFR_MSK_CCTL1;
         `AFR_OFS_CLKSEL:  wmask_of = `AFR_MSK_CLKSEL;
         `AFR_OFS_DAC_LO:  wmask_of = `AFR_MSK_DAC_LO;
         `AFR_OFS_DAC_HI:  wmask_of = 8'hFF;
         `AFR_OFS_DAC_CTL: wmask_of = `AFR_MSK_DAC_CTL;
         `AFR_OFS_OPAMP:   wmask_of = `AFR_MSK_OPAMP;
         `AFR_OFS_VCMSW:   wmask_of = `AFR_MSK_VCMSW;
         default:          wmask_of = 8'h00;
      endcase
   endfunction

   // Two-bit gain decode shared by reference and converter fields
   function automatic logic [2:0] g2_log2(input logic [1:0] c);
      case (c)
         2'b00:   g2_log2 = 3'd0;
         2'b01:   g2_log2 = 3'd1;
         2'b10:   g2_log2 = 3'd2;
         default: g2_log2 = 3'd0;
      endcase
   endfunction

   wire [7:0] wmask = wmask_of(bus.addr);
   wire [7:0] wd_m  = bus.wdata & wmask;
   wire       is_res = bus.addr == `AFR_OFS_RES_LO ||
                       bus.addr == `AFR_OFS_RES_MID ||
                       bus.addr == `AFR_OFS_RES_HI;
   // Result byte picked by offset for the read path
   wire [7:0] res_byte = (bus.addr == `AFR_OFS_RES_LO)  ? result_r[7:0]  :
                         (bus.addr == `AFR_OFS_RES_MID) ? result_r[15:8] :
                         result_r[23:16];

   // Storage and registered read data; result writes masked off
   // writes dropped
   afr_regfile #(
      .AW (AW),
      .N  (15)
   ) u_mem (
      .clk   (clk),
      .srst  (srst),
      .we    (bus.wr && !is_res),
      .waddr (bus.addr),
      .wdata (bus.wdata),
      .wmask (wmask),
      .re    (bus.rd),
      .raddr (bus.addr),
      .xsel  (is_res),
      .xdata (res_byte),
      .rdata (rdata)
   );

   // Live copies of steering registers
   // reset to zero
   always_ff @(posedge clk) begin
      if (srst) begin
         gain_r   <= `AFR_RST_ZERO;
         inconn_r <= `AFR_RST_ZERO;
         chsel_r  <= `AFR_RST_ZERO;
         dacctl_r <= `AFR_RST_ZERO;
      end else begin
         if (wr_gain)   gain_r   <= wd_m;
         if (wr_inconn) inconn_r <= wd_m;
         if (wr_chsel)  chsel_r  <= wd_m;
         if (wr_dacctl) dacctl_r <= wd_m;
      end
   end

   // D/A code with low-nibble shadow
   // shadow then copy
   always_ff @(posedge clk) begin
      if (srst) begin
         dac_shadow_r <= 4'h0;
         dac_lo_r     <= 4'h0;
         dac_hi_r     <= 8'h00;
      end else begin
         if (wr_daclo) dac_shadow_r <= bus.wdata[3:0];
         if (wr_dachi) begin
            dac_hi_r <= bus.wdata;
            dac_lo_r <= wr_daclo ? bus.wdata[3:0] : dac_shadow_r;
         end
      end
   end

   // Conversion result sampled each cycle, read-only to software
   always_ff @(posedge clk) begin
      if (srst) result_r <= 24'h00_0000;
      else      result_r <= conv_result;
   end

   // Outputs decoded from live registers
   always_ff @(posedge clk) begin
      if (srst) begin
         front           <= '0;
         ref_gain_den    <= 8'h01;
         conv_gain_log2  <= 3'd0;
         amp_gain        <= 8'h01;
         offset_quarters <= 2'd0;
         offset_neg      <= 1'b0;
         gain_reserved   <= 1'b0;
         chan_reserved   <= 1'b0;
         dac             <= '0;
         dac_amp_route_eff <= 1'b0;
      end else begin
         front.ref_gain_sel    <= gain_r[6:5];
         front.conv_gain_sel   <= gain_r[4:3];
         front.amp_gain_sel    <= gain_r[2:0];
         front.input_short     <= inconn_r[`AFR_BIT_SHORT];
         front.input_cross_sel <= inconn_r[5:4];
         front.offset_sel      <= inconn_r[3:1];
         front.neg_input_sel   <= chsel_r[7:4];
         front.pos_input_sel   <= chsel_r[3:0];
         ref_gain_den    <= 8'h01 << g2_log2(gain_r[6:5]);
         conv_gain_log2  <= g2_log2(gain_r[4:3]);
         amp_gain        <= 8'h01 << gain_r[2:0];
         offset_quarters <= inconn_r[2:1];
         offset_neg      <= inconn_r[3] && (inconn_r[2:1] != 2'b00);
         gain_reserved   <= gain_r[6:5] == `AFR_GAIN2_RSVD ||
                            gain_r[4:3] == `AFR_GAIN2_RSVD;
         chan_reserved   <= chsel_r[7:4] > `AFR_NEG_MAX ||
                            chsel_r[3:0] > `AFR_POS_MAX;
         dac.dac_enable    <= dacctl_r[`AFR_BIT_DAC_EN];
         dac.dac_ref_sel   <= dacctl_r[`AFR_BIT_DAC_REF];
         dac.dac_pin_route <= dacctl_r[`AFR_BIT_DAC_PIN];
         dac.dac_amp_route <= dacctl_r[`AFR_BIT_DAC_AMP];
         dac.code          <= {dac_hi_r, dac_lo_r};
         dac_amp_route_eff <= dacctl_r[`AFR_BIT_DAC_AMP] &&
                              dacctl_r[`AFR_BIT_DAC_EN] && amp_pin_func_sel;
      end
   end

endmodule // afr_regs

/* tb/afr_regs_asserts.sv */
// Concurrent checks on the AFE register bank ports
// Assumes one clock clk and synchronous active-high srst
`include "afr_cfg.svh"
module afr_regs_asserts
   import afr_pkg::*;
#(
   parameter int AW = `AFR_ADDR_W
) (
   // Clock and reset
   input wire logic          clk,
   input wire logic          srst,
   // Register port
   input wire logic [AW-1:0] addr,
   input wire logic [7:0]    wdata,
   input wire logic          wr,
   input wire logic          rd,
   input wire logic [7:0]    rdata,
   input wire logic [23:0]   conv_result,
   // Decoded controls
   input wire afr_front_s    front,
   input wire logic [7:0]    ref_gain_den,
   input wire logic [2:0]    conv_gain_log2,
   input wire logic [7:0]    amp_gain,
   input wire logic [1:0]    offset_quarters,
   input wire logic          offset_neg,
   input wire logic          gain_reserved,
   input wire logic          chan_reserved,
   input wire afr_dac_s      dac,
   input wire logic          dac_amp_route_eff,
   input wire logic          amp_pin_func_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Settled decode relations once fields have stood three cycles
   property p_ref;
      $stable(front) [*3] |-> ref_gain_den == ((front.ref_gain_sel == 2'h1)
         ? 8'h02 : (front.ref_gain_sel == 2'h2) ? 8'h04 : 8'h01);
   endproperty
   a_ref: assert property (p_ref) else $error("ref gain decode wrong");
   property p_conv;
      $stable(front) [*3] |-> conv_gain_log2 == ((front.conv_gain_sel ==
         2'h3) ? 3'h0 : {1'b0, front.conv_gain_sel}) && gain_reserved ==
         (front.conv_gain_sel == 2'h3 || front.ref_gain_sel == 2'h3);
   endproperty
   a_conv: assert property (p_conv) else $error("conv gain wrong");
   property p_amp;
      $stable(front) [*3] |-> amp_gain == (8'h01 << front.amp_gain_sel);
   endproperty
   a_amp: assert property (p_amp) else $error("amp gain wrong");
   property p_ofs;
      $stable(front) [*3] |-> offset_quarters == front.offset_sel[1:0] &&
         (front.offset_sel[1:0] == 2'h0 || offset_neg == front.offset_sel[2]);
   endproperty
   a_ofs: assert property (p_ofs) else $error("offset decode wrong");
   property p_chan;
      $stable(front) [*3] |-> chan_reserved == (front.neg_input_sel > 4'h8
         || front.pos_input_sel > 4'h7);
   endproperty
   a_chan: assert property (p_chan) else $error("channel flag wrong");
   // Active code moves only after a high code write
   property p_dac_code;
      !$stable(dac.code) && !$past(srst) |-> $past(wr, 2) &&
         $past(addr, 2) == `AFR_OFS_DAC_HI;
   endproperty
   a_dac_code: assert property (p_dac_code) else $error("code moved");
   // Low result byte reads the converter value two edges back
   property p_res;
      rd && !$past(srst) && addr == `AFR_OFS_RES_LO |=>
         rdata == $past(conv_result[7:0], 2);
   endproperty
   a_res: assert property (p_res) else $error("result byte wrong");
   property p_eff;
      ($stable(dac) && $stable(amp_pin_func_sel)) [*3] |->
         dac_amp_route_eff == (dac.dac_amp_route & dac.dac_enable &
         amp_pin_func_sel);
   endproperty
   a_eff: assert property (p_eff) else $error("amp route wrong");
   property p_reset;
      disable iff (1'b0) srst |=> dac == '0 && front == '0 &&
         amp_gain == 8'h01 && ref_gain_den == 8'h01;
   endproperty
   a_reset: assert property (p_reset) else $error("reset values wrong");
   property p_rdq;
      !$past(rd) |-> rdata == 8'h00;
   endproperty
   a_rdq: assert property (p_rdq) else $error("read data not quiet");
   property p_unmapped;
      rd && addr == 4'hF |=> rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("hole not 0");

   // Main scenarios reached
   c_hi: cover property (wr && addr == `AFR_OFS_DAC_HI);
   c_lo: cover property (wr && addr == `AFR_OFS_DAC_LO);
   c_eff: cover property (dac_amp_route_eff);
endmodule // afr_regs_asserts

bind afr_regs afr_regs_asserts #(.AW(AW)) u_afr_chk (.clk(clk),
   .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .conv_result(conv_result), .front(front), .ref_gain_den(ref_gain_den),
   .conv_gain_log2(conv_gain_log2), .amp_gain(amp_gain),
   .offset_quarters(offset_quarters), .offset_neg(offset_neg),
   .gain_reserved(gain_reserved), .chan_reserved(chan_reserved),
   .dac(dac), .dac_amp_route_eff(dac_amp_route_eff),
   .amp_pin_func_sel(amp_pin_func_sel));

/* tb/afr_regs_bench.sv */
// Self-checking bench for the AFE register bank
// Assumes one-cycle reads, writes decoded within three cycles
module afr_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import afr_pkg::*;
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, sel = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, ref_den, amp_g;
   logic [23:0] conv_result = 24'h00_0000;
   logic [2:0] conv_l2;
   logic [1:0] ofs_q;
   logic ofs_n, g_rsv, c_rsv, eff;
   afr_front_s front;
   afr_dac_s dac;
   int miscompares = 0, check_count = 0;
   // Readable bits, reset values per offset
   localparam logic [7:0] MSK [15] = '{8'h87, 8'h7F, 8'h7E, 8'hFF, 8'h56,
      8'h34, 8'h12, 8'hFD, 8'hE6, 8'h1F, 8'h0F, 8'hFF, 8'hC3, 8'h8F, 8'h0F};
   localparam logic [7:0] RST [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0A};

   afr_regs dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .conv_result(conv_result),
      .front(front), .ref_gain_den(ref_den), .conv_gain_log2(conv_l2),
      .amp_gain(amp_g), .offset_quarters(ofs_q), .offset_neg(ofs_n),
      .gain_reserved(g_rsv), .chan_reserved(c_rsv), .dac(dac),
      .dac_amp_route_eff(eff), .amp_pin_func_sel(sel));

   // Clock generator
   initial begin
      forever #2.5 clk = ~clk;
   end
   // Compare and count
   task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", {16'h0000, e}, {16'h0000, rdata});
   endtask
   task settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task s_reset_vals;
      chk("amp_gain", 24'h00_0001, {16'h0000, amp_g});
      chk("dac", 24'h00_0000, {8'h00, dac});
      for (int i = 0; i < 15; i++) begin
         if (i < 4 || i > 6) rd_chk(i[3:0], RST[i]);
      end
   endtask
   task s_gain;
      logic [7:0] d;
      for (int r = 0; r < 4; r++) begin
         for (int a = 0; a < 8; a++) begin
            d = {1'b1, r[1:0], 2'(3 - r), a[2:0]};
            wr_reg(4'h1, d);
            settle();
            chk("ref", (r == 1) ? 2 : (r == 2) ? 4 : 1, ref_den);
            chk("conv", (r == 0) ? 0 : 3 - r, conv_l2);
            chk("amp", 24'h1 << a, amp_g);
            chk("rsv", r == 0 || r == 3, g_rsv);
            rd_chk(4'h1, d & 8'h7F);
         end
      end
   endtask
   task s_offset;
      for (int o = 0; o < 8; o++) begin
         wr_reg(4'h2, {4'b1111, o[2:0], 1'b1});
         settle();
         chk("ofs_q", o % 4, ofs_q);
         if (o % 4 != 0) chk("ofs_n", o / 4, ofs_n);
         chk("short", 24'h1, front.input_short);
         chk("cross", 24'h3, front.input_cross_sel);
      end
      wr_reg(4'h2, 8'h00);
      settle();
      chk("short", 24'h0, front.input_short);
   endtask
   task s_chan;
      for (int n = 0; n < 16; n++) begin
         wr_reg(4'h3, {n[3:0], ~n[3:0]});
         settle();
         chk("chan_rsv", n > 8 || 15 - n > 7, c_rsv);
         chk("neg_sel", n, front.neg_input_sel);
         chk("pos_sel", 15 - n, front.pos_input_sel);
         rd_chk(4'h3, {n[3:0], ~n[3:0]});
      end
      wr_reg(4'h3, 8'h70);
      settle();
      chk("chan_rsv", 24'h0, c_rsv);
      wr_reg(4'h3, 8'h87);
      settle();
      chk("chan_rsv", 24'h0, c_rsv);
   endtask
   task s_dac;
      wr_reg(4'hA, 8'hF5);
      settle();
      chk("code", 24'h0, dac.code);
      rd_chk(4'hA, 8'h05);
      wr_reg(4'hB, 8'hAB);
      settle();
      chk("code", 24'hAB5, dac.code);
      wr_reg(4'hA, 8'h0C);
      settle();
      chk("code", 24'hAB5, dac.code);
      wr_reg(4'hC, 8'hC3);
      @(posedge clk);
      sel <= 1'b1;
      settle();
      chk("flags", 24'hF, dac[15:12]);
      chk("eff", 24'h1, eff);
      wr_reg(4'hC, 8'h01);
      settle();
      chk("eff", 24'h0, eff);
      wr_reg(4'hC, 8'h81);
      @(posedge clk);
      sel <= 1'b0;
      settle();
      chk("eff", 24'h0, eff);
   endtask
   task s_access;
      @(posedge clk);
      conv_result <= 24'h12_3456;
      for (int i = 0; i < 15; i++) wr_reg(i[3:0], 8'hFF);
      for (int i = 0; i < 15; i++) rd_chk(i[3:0], MSK[i]);
      rd_chk(4'hF, 8'h00);
   endtask
   task do_reset(input int n);
      @(posedge clk);
      srst <= 1'b1;
      repeat (n) @(posedge clk);
      srst <= 1'b0;
      #1;
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      wrap_up();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      #1;
      s_reset_vals();
      s_gain();
      s_offset();
      s_chan();
      s_dac();
      s_access();
      do_reset(1);
      s_reset_vals();
      wrap_up();
   end
endmodule // afr_regs_bench
